/* File: verilog/cise_defines.svh */
`ifndef CISE_DEFINES_SVH
`define CISE_DEFINES_SVH

`define CISE_ZERO8 8'h00
`define CISE_ONE8 8'h01
`define CISE_PC_ONE 15'h0001
`define CISE_PC_RESET 15'h0000
`define CISE_W_RESET 8'h00
`define CISE_ADDR_ZERO 7'h00
`define CISE_WDT_ZERO 8'h00
`define CISE_FLAG_SET 1'b1
`define CISE_FLAG_CLR 1'b0
`define CISE_DEST_W 1'b0
`define CISE_DEST_F 1'b1

`define CISE_REG_WREG 2'h0
`define CISE_REG_STATUS 2'h1
`define CISE_REG_PCL 2'h2
`define CISE_REG_PCH 2'h3

`define CISE_ST_Z 0
`define CISE_ST_PD 3
`define CISE_ST_TO 4

`endif

/* File: verilog/cise_pkg.sv */
package cise_pkg;

	typedef enum logic [2:0]
	{
		OP_NOP,
		OP_WATCHDOG_CLEAR,
		OP_CALL_VIA_WREG,
		OP_COMPLEMENT_FILE,
		OP_CLEAR_FILE,
		OP_CLEAR_WREG,
		OP_DECREMENT_FILE,
		OP_DECREMENT_SKIP_ZERO
	} cise_op_t;

	typedef enum logic [1:0]
	{
		ST_EXEC,
		ST_CALL2,
		ST_SKIP
	} cise_state_t;

endpackage

/* File: verilog/cise_core_if.sv */
interface cise_core_if;
	cise_pkg::cise_op_t op;
	logic [7:0] file_rdata;
	logic [7:0] result;
	logic zero;
	logic [7:0] w_val;
	logic [7:0] status_val;
	logic [14:0] pc_val;
	logic [1:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic w_wr;
	logic [7:0] rdata;

	modport alu_mp (input op, input file_rdata, output result, output zero);
	modport alu_user (output op, output file_rdata, input result, input zero);
	modport rp_mp (input w_val, input status_val, input pc_val, input reg_addr,
		input reg_wr, input reg_rd, input reg_wdata, output w_wr, output rdata);
	modport rp_user (output w_val, output status_val, output pc_val, output reg_addr,
		output reg_wr, output reg_rd, output reg_wdata, input w_wr, input rdata);
endinterface

/* File: verilog/cise_alu.sv */
`include "cise_defines.svh"

module cise_alu
(
	cise_core_if.alu_mp bus
);
	wire [7:0] inverted;
	wire [7:0] decremented;

	assign inverted = ~bus.file_rdata;
	assign decremented = bus.file_rdata - `CISE_ONE8;

	// Clear ops and anything else fall through to zero
	assign bus.result = (bus.op == cise_pkg::OP_COMPLEMENT_FILE) ? inverted :
		(bus.op == cise_pkg::OP_DECREMENT_FILE ||
		bus.op == cise_pkg::OP_DECREMENT_SKIP_ZERO) ? decremented : `CISE_ZERO8;
	assign bus.zero = (bus.result == `CISE_ZERO8);
endmodule

/* File: verilog/cise_regport.sv */
`include "cise_defines.svh"

module cise_regport
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	cise_core_if.rp_mp bus
);
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	wire [7:0] sel_data;

	assign bus.w_wr = bus.reg_wr && (bus.reg_addr == `CISE_REG_WREG);
	assign sel_data = (bus.reg_addr == `CISE_REG_WREG) ? bus.w_val :
		(bus.reg_addr == `CISE_REG_STATUS) ? bus.status_val :
		(bus.reg_addr == `CISE_REG_PCL) ? bus.pc_val[7:0] : {1'b0, bus.pc_val[14:8]};
	// Data valid only in the cycle after the strobe
	assign rdata_d = bus.reg_rd ? sel_data : `CISE_ZERO8;
	assign bus.rdata = rdata_q;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			rdata_q <= `CISE_ZERO8;
		else
			rdata_q <= rdata_d;
	end
endmodule

/* File: verilog/cise_exec.sv */
// The placing of the registers and the plain strobed port were decided locally.
`include "cise_defines.svh"

module cise_exec
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic op_valid_i,
	input wire cise_pkg::cise_op_t op_i,
	input wire logic [6:0] file_addr_i,
	input wire logic dest_sel_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic [6:0] pc_upper_latch_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic op_ready_o,
	output logic file_we_o,
	output logic [6:0] file_addr_o,
	output logic [7:0] file_wdata_o,
	output logic [7:0] wreg_o,
	output logic [14:0] pc_o,
	output logic stack_push_o,
	output logic [14:0] stack_top_o,
	output logic wdt_clear_o,
	output logic [7:0] wdt_load_o,
	output logic prescaler_clear_o,
	output logic zero_flag_o,
	output logic timeout_flag_o,
	output logic power_down_flag_o,
	output logic [7:0] reg_rdata_o
);
	function automatic logic writes_dest(input cise_pkg::cise_op_t op);
		writes_dest = (op == cise_pkg::OP_COMPLEMENT_FILE) ||
			(op == cise_pkg::OP_DECREMENT_FILE) ||
			(op == cise_pkg::OP_DECREMENT_SKIP_ZERO);
	endfunction

	function automatic logic [14:0] inc_pc(input logic [14:0] pc);
		inc_pc = pc + `CISE_PC_ONE;
	endfunction

	cise_core_if cif();

	cise_pkg::cise_state_t state_q;
	cise_pkg::cise_state_t state_d;
	logic ready_q;
	logic [7:0] w_q;
	logic [7:0] w_d;
	logic [14:0] pc_q;
	logic [14:0] pc_d;
	logic z_q;
	logic z_d;
	logic to_q;
	logic to_d;
	logic pd_q;
	logic pd_d;
	logic fwe_q;
	logic [6:0] faddr_q;
	logic [7:0] fwdata_q;
	logic push_q;
	logic [14:0] top_q;
	logic wdt_q;
	logic [7:0] wdt_load_q;

	wire take;
	wire cise_pkg::cise_op_t op_x;
	wire is_wdt;
	wire is_call_via_wreg_op;
	wire is_clear_file_op;
	wire is_clear_wreg_op;
	wire is_skipop;
	wire is_zop;
	wire to_file;
	wire to_w;
	wire [7:0] status_byte;

	assign take = op_valid_i && ready_q;
	// Skipped slot still takes a fetch, but its opcode is dropped
	assign op_x = (state_q == cise_pkg::ST_SKIP) ? cise_pkg::OP_NOP : op_i;
	assign is_wdt = take && (op_x == cise_pkg::OP_WATCHDOG_CLEAR);
	assign is_call_via_wreg_op = take && (op_x == cise_pkg::OP_CALL_VIA_WREG);
	assign is_clear_file_op = take && (op_x == cise_pkg::OP_CLEAR_FILE);
	assign is_clear_wreg_op = take && (op_x == cise_pkg::OP_CLEAR_WREG);
	assign is_skipop = take && (op_x == cise_pkg::OP_DECREMENT_SKIP_ZERO);
	// Skip op kept out so its flags stand
	assign is_zop = take && (op_x == cise_pkg::OP_COMPLEMENT_FILE ||
		op_x == cise_pkg::OP_DECREMENT_FILE);

	assign cif.op = take ? op_x : cise_pkg::OP_NOP;
	assign cif.file_rdata = file_rdata_i;

	assign to_file = is_clear_file_op || (take && writes_dest(op_x) && dest_sel_i == `CISE_DEST_F);
	assign to_w = is_clear_wreg_op || (take && writes_dest(op_x) && dest_sel_i == `CISE_DEST_W);

	// Instruction write to W beats a same-cycle software write
	assign w_d = to_w ? cif.result : (cif.w_wr ? reg_wdata_i : w_q);
	assign z_d = (is_clear_file_op || is_clear_wreg_op) ? `CISE_FLAG_SET : (is_zop ? cif.zero : z_q);
	assign to_d = is_wdt ? `CISE_FLAG_SET : to_q;
	assign pd_d = is_wdt ? `CISE_FLAG_SET : pd_q;
	assign pc_d = is_call_via_wreg_op ? {pc_upper_latch_i, w_q} : (take ? inc_pc(pc_q) : pc_q);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			cise_pkg::ST_EXEC:
			begin
				if (is_call_via_wreg_op)
					state_d = cise_pkg::ST_CALL2;
				else if (is_skipop && cif.zero)
					state_d = cise_pkg::ST_SKIP;
			end
			cise_pkg::ST_CALL2:
				state_d = cise_pkg::ST_EXEC;
			cise_pkg::ST_SKIP:
			begin
				if (take)
					state_d = cise_pkg::ST_EXEC;
			end
			default:
				state_d = cise_pkg::ST_EXEC;
		endcase
	end

	cise_alu u_alu
	(
		.bus(cif.alu_mp)
	);

	assign status_byte = ({7'h00, z_q} << `CISE_ST_Z) | ({7'h00, pd_q} << `CISE_ST_PD) |
		({7'h00, to_q} << `CISE_ST_TO);
	assign cif.w_val = w_q;
	assign cif.status_val = status_byte;
	assign cif.pc_val = pc_q;
	assign cif.reg_addr = reg_addr_i;
	assign cif.reg_wr = reg_wr_i;
	assign cif.reg_rd = reg_rd_i;
	assign cif.reg_wdata = reg_wdata_i;

	cise_regport u_regport
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.bus(cif.rp_mp)
	);

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state_q <= cise_pkg::ST_EXEC;
			ready_q <= `CISE_FLAG_CLR;
			w_q <= `CISE_W_RESET;
			pc_q <= `CISE_PC_RESET;
			z_q <= `CISE_FLAG_CLR;
			to_q <= `CISE_FLAG_SET;
			pd_q <= `CISE_FLAG_SET;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= (state_d != cise_pkg::ST_CALL2);
			w_q <= w_d;
			pc_q <= pc_d;
			z_q <= z_d;
			to_q <= to_d;
			pd_q <= pd_d;
		end
	end

	// Side-effect strobes, one cycle each
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			fwe_q <= `CISE_FLAG_CLR;
			faddr_q <= `CISE_ADDR_ZERO;
			fwdata_q <= `CISE_ZERO8;
			push_q <= `CISE_FLAG_CLR;
			top_q <= `CISE_PC_RESET;
			wdt_q <= `CISE_FLAG_CLR;
			wdt_load_q <= `CISE_WDT_ZERO;
		end
		else
		begin
			fwe_q <= to_file;
			faddr_q <= file_addr_i;
			fwdata_q <= cif.result;
			push_q <= is_call_via_wreg_op;
			top_q <= is_call_via_wreg_op ? inc_pc(pc_q) : top_q;
			wdt_q <= is_wdt;
			wdt_load_q <= `CISE_WDT_ZERO;
		end
	end

	assign op_ready_o = ready_q;
	assign file_we_o = fwe_q;
	assign file_addr_o = faddr_q;
	assign file_wdata_o = fwdata_q;
	assign wreg_o = w_q;
	assign pc_o = pc_q;
	assign stack_push_o = push_q;
	assign stack_top_o = top_q;
	assign wdt_clear_o = wdt_q;
	assign wdt_load_o = wdt_load_q;
	assign prescaler_clear_o = wdt_q;
	assign zero_flag_o = z_q;
	assign timeout_flag_o = to_q;
	assign power_down_flag_o = pd_q;
	assign reg_rdata_o = cif.rdata;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_call_via_wreg_op_taken;
		is_call_via_wreg_op;
	endsequence

	sequence s_call_via_wreg_op_flush;
		!op_ready_o ##1 op_ready_o;
	endsequence

	property p_wdt_clear;
		is_wdt |=> wdt_clear_o && prescaler_clear_o && wdt_load_o == `CISE_WDT_ZERO;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missed");

	property p_wdt_flags;
		is_wdt |=> timeout_flag_o && power_down_flag_o;
	endproperty
	a_wdt_flags: assert property (p_wdt_flags) else $error("timeout or power-down not set");

	property p_wdt_keeps_z;
		is_wdt |=> zero_flag_o == $past(z_q);
	endproperty
	a_wdt_keeps_z: assert property (p_wdt_keeps_z) else $error("watchdog clear moved zero");

	property p_call_via_wreg_op_push;
		s_call_via_wreg_op_taken |=> stack_push_o && stack_top_o == inc_pc($past(pc_q));
	endproperty
	a_call_via_wreg_op_push: assert property (p_call_via_wreg_op_push) else $error("bad return address push");

	property p_call_via_wreg_op_pc;
		s_call_via_wreg_op_taken |=> pc_o == {$past(pc_upper_latch_i), $past(w_q)};
	endproperty
	a_call_via_wreg_op_pc: assert property (p_call_via_wreg_op_pc) else $error("bad call target");

	property p_call_via_wreg_op_two;
		s_call_via_wreg_op_taken |=> s_call_via_wreg_op_flush and ($stable(zero_flag_o) [*2]);
	endproperty
	a_call_via_wreg_op_two: assert property (p_call_via_wreg_op_two) else $error("call timing or flags wrong");

	property p_complement_file_op_file;
		take && op_x == cise_pkg::OP_COMPLEMENT_FILE && dest_sel_i == `CISE_DEST_F
			|=> file_we_o && file_wdata_o == ~$past(file_rdata_i);
	endproperty
	a_complement_file_op_file: assert property (p_complement_file_op_file) else $error("complement write wrong");

	property p_dest_w;
		take && writes_dest(op_x) && dest_sel_i == `CISE_DEST_W
			|=> !file_we_o && wreg_o == $past(cif.result);
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("W destination wrong");

	property p_clear_file_op;
		is_clear_file_op |=> file_we_o && file_wdata_o == `CISE_ZERO8 && zero_flag_o;
	endproperty
	a_clear_file_op: assert property (p_clear_file_op) else $error("clear file wrong");

	property p_clear_wreg_op;
		is_clear_wreg_op |=> wreg_o == `CISE_ZERO8 && zero_flag_o && !file_we_o;
	endproperty
	a_clear_wreg_op: assert property (p_clear_wreg_op) else $error("clear W wrong");

	property p_decrement_file_op;
		take && op_x == cise_pkg::OP_DECREMENT_FILE && dest_sel_i == `CISE_DEST_F
			|=> file_wdata_o == $past(file_rdata_i) - `CISE_ONE8
			&& zero_flag_o == (file_wdata_o == `CISE_ZERO8);
	endproperty
	a_decrement_file_op: assert property (p_decrement_file_op) else $error("decrement wrong");

	property p_dsz_flags;
		is_skipop |=> $stable(zero_flag_o) && $stable(timeout_flag_o)
			&& $stable(power_down_flag_o);
	endproperty
	a_dsz_flags: assert property (p_dsz_flags) else $error("skip op moved a flag");

	property p_skip_nop;
		is_skipop && cif.zero ##1 (op_valid_i && op_ready_o)
			|=> !file_we_o && !stack_push_o && pc_o == inc_pc($past(pc_q));
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("skipped slot executed");

	property p_noskip;
		is_skipop && !cif.zero |=> state_q == cise_pkg::ST_EXEC;
	endproperty
	a_noskip: assert property (p_noskip) else $error("skip on nonzero");

	property p_addr;
		file_we_o |-> file_addr_o == $past(file_addr_i);
	endproperty
	a_addr: assert property (p_addr) else $error("file address not held");
endmodule

/* File: verification/cise_file_model.sv */
module cise_file_model
(
	input wire logic core_clk_i,
	input wire logic file_we_i,
	input wire logic [6:0] file_waddr_i,
	input wire logic [7:0] file_wdata_i,
	input wire logic [6:0] file_raddr_i,
	output logic [7:0] file_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [128];
	wire logic hit = file_we_i && (file_waddr_i == file_raddr_i);
	// Bypass, else back-to-back ops on one address read stale data
	assign file_rdata_o = hit ? file_wdata_i : mem[file_raddr_i];
	always @(posedge core_clk_i)
	begin
		if (file_we_i)
			mem[file_waddr_i] <= file_wdata_i;
	end
endmodule

/* File: verification/tb_cise_exec.sv */
module tb_cise_exec;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i, srst_i, op_valid_i, dest_sel_i, reg_wr_i, reg_rd_i;
	cise_pkg::cise_op_t op_i;
	logic [6:0] file_addr_i, pc_upper_latch_i, file_addr_o;
	logic [7:0] file_rdata_i, reg_wdata_i, wreg_o, file_wdata_o, wdt_load_o, reg_rdata_o;
	logic [1:0] reg_addr_i;
	logic op_ready_o, file_we_o, stack_push_o, wdt_clear_o, prescaler_clear_o;
	logic zero_flag_o, timeout_flag_o, power_down_flag_o;
	logic [14:0] pc_o, stack_top_o, pc;
	int miscompares = 0;
	int comparisons = 0;
	logic [68:0] oq[$];
	logic [7:0] rq[$];
	logic [7:0] fm [128];
	logic [7:0] w;
	logic z, to, pd, skp;

	cise_exec u_cise_exec (.core_clk_i, .srst_i, .op_valid_i, .op_i, .file_addr_i, .dest_sel_i,
		.file_rdata_i, .pc_upper_latch_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
		.op_ready_o, .file_we_o, .file_addr_o, .file_wdata_o, .wreg_o, .pc_o, .stack_push_o,
		.stack_top_o, .wdt_clear_o, .wdt_load_o, .prescaler_clear_o, .zero_flag_o,
		.timeout_flag_o, .power_down_flag_o, .reg_rdata_o);
	cise_file_model u_cise_file_model (.core_clk_i, .file_we_i(file_we_o),
		.file_waddr_i(file_addr_o), .file_wdata_i(file_wdata_o), .file_raddr_i(file_addr_i),
		.file_rdata_o(file_rdata_i));

	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic poke(input logic [6:0] a, input logic [7:0] v);
		fm[a] = v;
		u_cise_file_model.mem[a] = v;
	endtask

	task automatic rst();
		srst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		srst_i <= 1'b0;
		{w, pc, z, to, pd, skp} = {8'h00, 15'h0000, 4'h6};
	endtask

	task automatic idle(input int n);
		@(posedge core_clk_i);
		op_valid_i <= 1'b0;
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		repeat (n) @(posedge core_clk_i);
	endtask

	task automatic reg_op(input logic wr, input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		op_valid_i <= 1'b0;
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		if (wr && a == 2'h0)
			w = v;
		if (!wr)
			rq.push_back(a == 2'h0 ? w : a == 2'h1 ? {3'h0, to, pd, 2'h0, z} :
				a == 2'h2 ? pc[7:0] : {1'b0, pc[14:8]});
	endtask

	task automatic exec(input cise_pkg::cise_op_t op, input logic [6:0] a, input logic d);
		logic [7:0] r;
		logic [6:0] lat;
		logic [14:0] top;
		logic we, res, push, wc;
		lat = 7'($urandom);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		op_valid_i <= 1'b1;
		op_i <= op;
		file_addr_i <= a;
		dest_sel_i <= d;
		pc_upper_latch_i <= lat;
		#1;
		// Held while refused after a call
		while (op_ready_o !== 1'b1)
		begin
			@(posedge core_clk_i);
			#1;
		end
		pc = pc + 15'h0001;
		top = pc;
		{r, we, res, push, wc} = 12'h000;
		if (skp)
			skp = 1'b0;
		else
			case (op)
			cise_pkg::OP_WATCHDOG_CLEAR: {wc, to, pd} = 3'h7;
			cise_pkg::OP_CALL_VIA_WREG: {push, pc} = {1'b1, lat, w};
			cise_pkg::OP_COMPLEMENT_FILE: {res, r} = {1'b1, ~fm[a]};
			cise_pkg::OP_CLEAR_FILE: {we, z} = 2'h3;
			cise_pkg::OP_CLEAR_WREG: {z, w} = 9'h100;
			cise_pkg::OP_DECREMENT_FILE: {res, r} = {1'b1, fm[a] - 8'h01};
			cise_pkg::OP_DECREMENT_SKIP_ZERO:
				{res, r, skp} = {1'b1, fm[a] - 8'h01, fm[a] == 8'h01};
			default: ;
			endcase
		if (res && op != cise_pkg::OP_DECREMENT_SKIP_ZERO)
			z = (r == 8'h00);
		we = we | (res & d);
		if (we)
			fm[a] = r;
		else if (res)
			w = r;
		oq.push_back({we, we ? {a, r} : 15'h0, w, pc, z, to, pd, push, push ? top : 15'h0,
			wc, wc, 8'h00, !push});
	endtask

	always @(posedge core_clk_i)
	begin
		logic tk;
		logic [68:0] e;
		logic [7:0] e8;
		tk = op_valid_i && op_ready_o && !srst_i;
		e8 = (reg_rd_i && !srst_i) ? rq.pop_front() : 8'h00;
		#1;
		comparisons++;
		if (reg_rdata_o !== e8)
		begin
			miscompares++;
			$display("unexpected at %0t: read data %h, want %h", $time, reg_rdata_o, e8);
		end
		if (tk)
		begin
			e = oq.pop_front();
			comparisons++;
			if ({file_we_o, file_we_o ? {file_addr_o, file_wdata_o} : 15'h0, wreg_o, pc_o,
				zero_flag_o, timeout_flag_o, power_down_flag_o, stack_push_o,
				stack_push_o ? stack_top_o : 15'h0, wdt_clear_o, prescaler_clear_o,
				wdt_load_o, op_ready_o} !== e)
			begin
				miscompares++;
				$display("unexpected at %0t: op result differs, want %h", $time, e);
			end
		end
	end

	initial
	begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		#300000;
		miscompares++;
		end_sim();
	end

	initial
	begin
		{op_valid_i, reg_wr_i, reg_rd_i, dest_sel_i} = 4'h0;
		op_i = cise_pkg::OP_NOP;
		{file_addr_i, pc_upper_latch_i, reg_addr_i, reg_wdata_i} = 24'h000000;
		void'($urandom(70404));
		rst();
		for (int i = 0; i < 128; i++)
			poke(7'(i), 8'($urandom));
		poke(7'h05, 8'h01);
		poke(7'h06, 8'h00);
		poke(7'h07, 8'hFF);
		reg_op(1'b0, 2'h1, 8'h00);
		reg_op(1'b1, 2'h1, 8'h00);
		reg_op(1'b0, 2'h1, 8'h00);
		reg_op(1'b1, 2'h0, 8'($urandom));
		reg_op(1'b0, 2'h0, 8'h00);
		for (int i = 0; i < 16; i++)
			exec(cise_pkg::cise_op_t'(i[2:0]), i[3] ? 7'h7F : 7'h00, i[3]);
		// Drains a skip the loop may have left pending
		exec(cise_pkg::OP_NOP, 7'h00, 1'b0);
		exec(cise_pkg::OP_DECREMENT_SKIP_ZERO, 7'h05, 1'b1);
		exec(cise_pkg::OP_CALL_VIA_WREG, 7'h00, 1'b0);
		exec(cise_pkg::OP_DECREMENT_SKIP_ZERO, 7'h05, 1'b0);
		exec(cise_pkg::OP_DECREMENT_FILE, 7'h06, 1'b0);
		exec(cise_pkg::OP_COMPLEMENT_FILE, 7'h07, 1'b1);
		exec(cise_pkg::OP_WATCHDOG_CLEAR, 7'h07, 1'b0);
		exec(cise_pkg::OP_CALL_VIA_WREG, 7'h00, 1'b0);
		exec(cise_pkg::OP_CALL_VIA_WREG, 7'h00, 1'b0);
		reg_op(1'b0, 2'h2, 8'h00);
		reg_op(1'b0, 2'h3, 8'h00);
		for (int i = 0; i < 60; i++)
			exec(cise_pkg::cise_op_t'(3'($urandom)), 7'($urandom), 1'($urandom));
		idle(2);
		rst();
		reg_op(1'b0, 2'h1, 8'h00);
		exec(cise_pkg::OP_CLEAR_WREG, 7'h00, 1'b0);
		reg_op(1'b0, 2'h2, 8'h00);
		idle(3);
		end_sim();
	end
endmodule
